/* File: design/bit_op_and_call_decoder.sv */
// decode, clock-count and busy timing for string store, bit ops and calls
`timescale 1ns/1ps
`default_nettype none
module bit_op_and_call_decoder (
  input  wire logic                      clk_sys_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      insn_valid_in,
  input  wire bit_call_pkg::insn_bytes_t insn_in,
  input  wire logic                      protected_mode_in,
  input  wire logic                      addr_size_32_in,
  input  wire logic [31:0]               loop_count_in,
  input  wire logic [5:0]                scan_positions_in,
  input  wire logic [7:0]                component_clocks_in,
  output logic                           insn_ready_out,
  output var bit_call_pkg::op_kind_t     op_kind_out,
  output logic                           imm_index_out,
  output logic                           mem_operand_out,
  output logic                           wide_operand_out,
  output logic [31:0]                    total_clocks_out,
  output logic                           busy_out,
  output logic                           done_out,
  output logic                           unknown_out
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DONE
  } exec_state_t;

  bit_call_pkg::decode_t dec;
  exec_state_t           state_q;
  logic [31:0]           remain_q;
  logic [31:0]           total_d;
  logic [31:0]           iter_n;
  logic [31:0]           base_part;
  logic [31:0]           iter_part;
  logic [31:0]           call_part;
  logic                  accept;
  logic                  start;

  insn_class_decode u_decode (
    .insn_in           (insn_in),
    .protected_mode_in (protected_mode_in),
    .dec_out           (dec)
  );

  // the product is cut to the count width: counts near the top wrap like a 32-bit counter
  function automatic logic [31:0] mul_iter(input logic [31:0] n, input logic [15:0] per);
    logic [47:0] prod;
    prod     = {16'h0000, n} * {32'h00000000, per};
    mul_iter = prod[31:0];
  endfunction

  function automatic logic is_call(input bit_call_pkg::op_kind_t kind);
    is_call = (kind == bit_call_pkg::OP_NEAR_CALL) ||
              (kind == bit_call_pkg::OP_FAR_CALL) ||
              (kind == bit_call_pkg::OP_IND_CALL);
  endfunction

  function automatic logic [31:0] count_down(input logic [31:0] value);
    count_down = value - 32'h00000001;
  endfunction

  // count register width follows address size for the repeat prefix
  always_comb
  begin
    iter_n = 32'h00000000;
    case (dec.kind)
      bit_call_pkg::OP_REP_STORE:
      begin
        iter_n = addr_size_32_in ? loop_count_in : {16'h0000, loop_count_in[15:0]};
      end
      bit_call_pkg::OP_SCAN_FORWARD,
      bit_call_pkg::OP_SCAN_REVERSE:
      begin
        iter_n = {26'h0, scan_positions_in};
      end
      default:
      begin
        iter_n = 32'h00000000;
      end
    endcase
  end

  // calls add the target's component clocks; other kinds have no such term
  always_comb
  begin
    base_part = {16'h0000, dec.base_clocks};
    iter_part = mul_iter(iter_n, dec.iter_clocks);
    call_part = 32'h00000000;
    if (is_call(dec.kind))
    begin
      call_part = {24'h000000, component_clocks_in};
    end
    total_d = base_part + iter_part + call_part;
  end

  assign insn_ready_out = (state_q == ST_IDLE);
  assign accept         = insn_valid_in && insn_ready_out;
  // an undecodable instruction is taken but starts no count, so ready stays high
  assign start          = accept && (dec.kind != bit_call_pkg::OP_NONE);

  // the accepting cycle is the first of the count, so a total of one goes straight to done
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= (total_d > 32'h00000001) ? ST_EXEC : ST_DONE;
          end
        end
        ST_EXEC:
        begin
          if (remain_q == 32'h00000001)
          begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // cycles still owed counting the current one; only meaningful while executing
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      remain_q <= 32'h00000000;
    end
    else if (start)
    begin
      remain_q <= count_down(total_d);
    end
    else if (state_q == ST_EXEC)
    begin
      remain_q <= count_down(remain_q);
    end
  end

  // decoded attributes hold until the next accepted instruction
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      op_kind_out      <= bit_call_pkg::OP_NONE;
      imm_index_out    <= 1'b0;
      mem_operand_out  <= 1'b0;
      wide_operand_out <= 1'b0;
    end
    else if (accept)
    begin
      op_kind_out      <= dec.kind;
      imm_index_out    <= dec.imm_index;
      mem_operand_out  <= dec.mem_operand;
      wide_operand_out <= dec.wide_operand;
    end
  end

  // unknown opcodes are taken too and leave a total of zero behind
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      total_clocks_out <= 32'h00000000;
    end
    else if (accept)
    begin
      total_clocks_out <= total_d;
    end
  end

  // a one-cycle flag, so a refused or idle cycle clears it
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      unknown_out <= 1'b0;
    end
    else
    begin
      unknown_out <= accept && (dec.kind == bit_call_pkg::OP_NONE);
    end
  end

  // decoded straight from the state so neither lags the count by a cycle
  assign busy_out = (state_q == ST_EXEC);
  assign done_out = (state_q == ST_DONE);

endmodule
`default_nettype wire

/* File: common/bit_call_pkg.sv */
// shared encodings, clock-count constants and carrier types for the decoder
`default_nettype none
package bit_call_pkg;

  localparam logic [7:0] REPNE_PREFIX      = 8'hF2;
  localparam logic [6:0] STORE_STRING_OP7  = 7'h55;
  localparam logic [7:0] TWO_BYTE_ESCAPE   = 8'h0F;
  localparam logic [7:0] OP_SCAN_FWD       = 8'hBC;
  localparam logic [7:0] OP_SCAN_REV       = 8'hBD;
  localparam logic [7:0] OP_BIT_IMM_GROUP  = 8'hBA;
  localparam logic [7:0] OP_TEST_REG       = 8'hA3;
  localparam logic [7:0] OP_COMPL_REG      = 8'hBB;
  localparam logic [7:0] OP_CLEAR_REG      = 8'hB3;
  localparam logic [7:0] OP_SET_REG        = 8'hAB;
  localparam logic [7:0] OP_CALL_NEAR      = 8'hE8;
  localparam logic [7:0] OP_CALL_FAR       = 8'h9A;
  localparam logic [7:0] OP_GROUP_FF       = 8'hFF;

  localparam logic [2:0] SUB_TEST          = 3'h4;
  localparam logic [2:0] SUB_SET           = 3'h5;
  localparam logic [2:0] SUB_CLEAR         = 3'h6;
  localparam logic [2:0] SUB_COMPL         = 3'h7;
  localparam logic [2:0] SUB_CALL_IND      = 3'h2;

  localparam int unsigned MODRM_REG_POS    = 3;
  localparam int unsigned MODRM_MOD_POS    = 6;
  localparam logic [1:0]  MOD_REGISTER     = 2'h3;

  localparam logic [15:0] CLK_STORE_BASE   = 16'h0005;
  localparam logic [15:0] CLK_STORE_ITER   = 16'h0005;
  localparam logic [15:0] CLK_SCANF_BASE   = 16'h000B;
  localparam logic [15:0] CLK_SCANR_BASE   = 16'h0009;
  localparam logic [15:0] CLK_SCAN_ITER    = 16'h0003;
  localparam logic [15:0] CLK_TEST_REG     = 16'h0003;
  localparam logic [15:0] CLK_TESTI_MEM    = 16'h0006;
  localparam logic [15:0] CLK_TESTR_MEM    = 16'h000C;
  localparam logic [15:0] CLK_MODI_REG     = 16'h0006;
  localparam logic [15:0] CLK_MODI_MEM     = 16'h0008;
  localparam logic [15:0] CLK_MODR_REG     = 16'h0006;
  localparam logic [15:0] CLK_MODR_MEM     = 16'h000D;
  localparam logic [15:0] CLK_CALL_NEAR    = 16'h0007;
  localparam logic [15:0] CLK_CALL_IND_MEM = 16'h000A;
  localparam logic [15:0] CLK_FAR_REAL     = 16'h0011;
  localparam logic [15:0] CLK_FAR_PROT     = 16'h0022;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_REP_STORE,
    OP_SCAN_FORWARD,
    OP_SCAN_REVERSE,
    OP_TEST_BIT,
    OP_TEST_COMPL,
    OP_TEST_CLEAR,
    OP_TEST_SET,
    OP_NEAR_CALL,
    OP_FAR_CALL,
    OP_IND_CALL
  } op_kind_t;

  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } insn_bytes_t;

  typedef struct packed {
    op_kind_t    kind;
    logic        imm_index;
    logic        mem_operand;
    logic        wide_operand;
    logic [15:0] base_clocks;
    logic [15:0] iter_clocks;
  } decode_t;

endpackage
`default_nettype wire

/* File: design/insn_class_decode.sv */
// combinational opcode classifier and base clock-count lookup
`timescale 1ns/1ps
`default_nettype none
module insn_class_decode (
  input  wire bit_call_pkg::insn_bytes_t insn_in,
  input  wire logic                      protected_mode_in,
  output var bit_call_pkg::decode_t      dec_out
);

  function automatic logic [2:0] modrm_sub(input logic [7:0] modrm);
    modrm_sub = modrm[bit_call_pkg::MODRM_REG_POS +: 3];
  endfunction

  function automatic logic modrm_is_mem(input logic [7:0] modrm);
    modrm_is_mem = modrm[bit_call_pkg::MODRM_MOD_POS +: 2] != bit_call_pkg::MOD_REGISTER;
  endfunction

  function automatic logic [15:0] pick(input logic mem, input logic [15:0] r,
                                       input logic [15:0] m);
    pick = mem ? m : r;
  endfunction

  always_comb
  begin
    dec_out = '0;
    dec_out.kind = bit_call_pkg::OP_NONE;
    if (insn_in.byte0 == bit_call_pkg::REPNE_PREFIX &&
        insn_in.byte1[7:1] == bit_call_pkg::STORE_STRING_OP7)
    begin
      dec_out.kind         = bit_call_pkg::OP_REP_STORE;
      dec_out.wide_operand = insn_in.byte1[0];
      dec_out.base_clocks  = bit_call_pkg::CLK_STORE_BASE;
      dec_out.iter_clocks  = bit_call_pkg::CLK_STORE_ITER;
    end
    else if (insn_in.byte0 == bit_call_pkg::TWO_BYTE_ESCAPE)
    begin
      dec_out.mem_operand  = modrm_is_mem(insn_in.byte2);
      dec_out.wide_operand = 1'b1;
      case (insn_in.byte1)
        bit_call_pkg::OP_SCAN_FWD:
        begin
          dec_out.kind        = bit_call_pkg::OP_SCAN_FORWARD;
          dec_out.base_clocks = bit_call_pkg::CLK_SCANF_BASE;
          dec_out.iter_clocks = bit_call_pkg::CLK_SCAN_ITER;
        end
        bit_call_pkg::OP_SCAN_REV:
        begin
          dec_out.kind        = bit_call_pkg::OP_SCAN_REVERSE;
          dec_out.base_clocks = bit_call_pkg::CLK_SCANR_BASE;
          dec_out.iter_clocks = bit_call_pkg::CLK_SCAN_ITER;
        end
        bit_call_pkg::OP_BIT_IMM_GROUP:
        begin
          dec_out.imm_index = 1'b1;
          case (modrm_sub(insn_in.byte2))
            bit_call_pkg::SUB_TEST:
            begin
              dec_out.kind        = bit_call_pkg::OP_TEST_BIT;
              dec_out.base_clocks = pick(dec_out.mem_operand, bit_call_pkg::CLK_TEST_REG,
                                         bit_call_pkg::CLK_TESTI_MEM);
            end
            bit_call_pkg::SUB_COMPL,
            bit_call_pkg::SUB_CLEAR,
            bit_call_pkg::SUB_SET:
            begin
              dec_out.kind = (modrm_sub(insn_in.byte2) == bit_call_pkg::SUB_COMPL) ?
                             bit_call_pkg::OP_TEST_COMPL :
                             (modrm_sub(insn_in.byte2) == bit_call_pkg::SUB_CLEAR) ?
                             bit_call_pkg::OP_TEST_CLEAR : bit_call_pkg::OP_TEST_SET;
              dec_out.base_clocks = pick(dec_out.mem_operand, bit_call_pkg::CLK_MODI_REG,
                                         bit_call_pkg::CLK_MODI_MEM);
            end
            default:
            begin
              dec_out.imm_index = 1'b0;
            end
          endcase
        end
        bit_call_pkg::OP_TEST_REG:
        begin
          dec_out.kind        = bit_call_pkg::OP_TEST_BIT;
          dec_out.base_clocks = pick(dec_out.mem_operand, bit_call_pkg::CLK_TEST_REG,
                                     bit_call_pkg::CLK_TESTR_MEM);
        end
        bit_call_pkg::OP_COMPL_REG,
        bit_call_pkg::OP_CLEAR_REG,
        bit_call_pkg::OP_SET_REG:
        begin
          dec_out.kind = (insn_in.byte1 == bit_call_pkg::OP_COMPL_REG) ?
                         bit_call_pkg::OP_TEST_COMPL :
                         (insn_in.byte1 == bit_call_pkg::OP_CLEAR_REG) ?
                         bit_call_pkg::OP_TEST_CLEAR : bit_call_pkg::OP_TEST_SET;
          dec_out.base_clocks = pick(dec_out.mem_operand, bit_call_pkg::CLK_MODR_REG,
                                     bit_call_pkg::CLK_MODR_MEM);
        end
        default:
        begin
          dec_out.mem_operand = 1'b0;
        end
      endcase
      if (dec_out.kind == bit_call_pkg::OP_NONE)
      begin
        dec_out.wide_operand = 1'b0;
        dec_out.mem_operand  = 1'b0;
      end
    end
    else if (insn_in.byte0 == bit_call_pkg::OP_CALL_NEAR)
    begin
      dec_out.kind         = bit_call_pkg::OP_NEAR_CALL;
      dec_out.wide_operand = 1'b1;
      dec_out.base_clocks  = bit_call_pkg::CLK_CALL_NEAR;
    end
    else if (insn_in.byte0 == bit_call_pkg::OP_CALL_FAR)
    begin
      dec_out.kind         = bit_call_pkg::OP_FAR_CALL;
      dec_out.wide_operand = 1'b1;
      dec_out.base_clocks  = protected_mode_in ? bit_call_pkg::CLK_FAR_PROT :
                                                 bit_call_pkg::CLK_FAR_REAL;
    end
    else if (insn_in.byte0 == bit_call_pkg::OP_GROUP_FF &&
             modrm_sub(insn_in.byte1) == bit_call_pkg::SUB_CALL_IND)
    begin
      dec_out.kind         = bit_call_pkg::OP_IND_CALL;
      dec_out.wide_operand = 1'b1;
      dec_out.mem_operand  = modrm_is_mem(insn_in.byte1);
      dec_out.base_clocks  = pick(dec_out.mem_operand, bit_call_pkg::CLK_CALL_NEAR,
                                  bit_call_pkg::CLK_CALL_IND_MEM);
    end
  end

endmodule
`default_nettype wire

/* File: verification/bit_op_and_call_decoder_monitor.sv */
// concurrent checks on the decoder ports, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor (
  input wire logic                      clk_sys_in,
  input wire logic                      arst_n_in,
  input wire logic                      insn_valid_in,
  input wire bit_call_pkg::insn_bytes_t insn_in,
  input wire logic                      protected_mode_in,
  input wire logic                      addr_size_32_in,
  input wire logic [31:0]               loop_count_in,
  input wire logic [5:0]                scan_positions_in,
  input wire logic [7:0]                component_clocks_in,
  input wire logic                      insn_ready_out,
  input wire logic [31:0]               total_clocks_out
);
  default clocking
    @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  wire logic        acc  = insn_valid_in && insn_ready_out;
  wire logic        esc  = acc && insn_in.byte0 == 8'h0F;
  wire logic        grp  = esc && insn_in.byte1 == 8'hBA;
  wire logic [1:0]  mod2 = insn_in.byte2[7:6];
  wire logic [1:0]  mod1 = insn_in.byte1[7:6];
  // only the low half counts when the short count register is selected
  wire logic [31:0] cnt  = addr_size_32_in ? loop_count_in : {16'h0, loop_count_in[15:0]};
  wire logic        rep  = acc && insn_in.byte0 == 8'hF2 && insn_in.byte1[7:1] == 7'h55;

  store_total_a: assert property (rep |=> total_clocks_out == 32'h5 + 32'h5 * $past(cnt))
    else $error("repeat store total wrong");
  scan_fwd_a: assert property (esc && insn_in.byte1 == 8'hBC |=>
    total_clocks_out == 32'hB + 32'h3 * $past(scan_positions_in)) else $error("forward scan total wrong");
  scan_rev_a: assert property (esc && insn_in.byte1 == 8'hBD |=>
    total_clocks_out == 32'h9 + 32'h3 * $past(scan_positions_in)) else $error("reverse scan total wrong");
  imm_test_a: assert property (grp && insn_in.byte2[5:3] == 3'h4 |=>
    total_clocks_out == (($past(mod2) == 2'h3) ? 32'h3 : 32'h6)) else $error("immediate test total wrong");
  imm_modify_a: assert property (grp && insn_in.byte2[5] && insn_in.byte2[4:3] != 2'h0 |=>
    total_clocks_out == (($past(mod2) == 2'h3) ? 32'h6 : 32'h8)) else $error("immediate modify total wrong");
  near_call_a: assert property (acc && insn_in.byte0 == 8'hE8 |=>
    total_clocks_out == 32'h7 + $past(component_clocks_in)) else $error("near call total wrong");
  far_call_a: assert property (acc && insn_in.byte0 == 8'h9A |=> total_clocks_out ==
    ($past(protected_mode_in) ? 32'h22 : 32'h11) + $past(component_clocks_in)) else $error("far call total wrong");
  ind_call_a: assert property (acc && insn_in.byte0 == 8'hFF && insn_in.byte1[5:3] == 3'h2 |=>
    total_clocks_out == (($past(mod1) == 2'h3) ? 32'h7 : 32'hA) + $past(component_clocks_in))
    else $error("indirect call total wrong");
  reg_index_a: assert property (esc && insn_in.byte1[7:5] == 3'h5 &&
    insn_in.byte1[2:0] == 3'h3 |=> total_clocks_out == (($past(insn_in.byte1) == 8'hA3) ?
    (($past(mod2) == 2'h3) ? 32'h3 : 32'hC) : (($past(mod2) == 2'h3) ? 32'h6 : 32'hD)))
    else $error("register-indexed total wrong");
endmodule

bind bit_op_and_call_decoder decoder_monitor u_monitor (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .insn_valid_in(insn_valid_in), .insn_in(insn_in),
  .protected_mode_in(protected_mode_in), .addr_size_32_in(addr_size_32_in),
  .loop_count_in(loop_count_in), .scan_positions_in(scan_positions_in),
  .component_clocks_in(component_clocks_in), .insn_ready_out(insn_ready_out),
  .total_clocks_out(total_clocks_out));
`default_nettype wire

/* File: verification/tb_bit_op_and_call_decoder.sv */
// self-checking bench for the string-store, bit-op and call decoder
`timescale 1ns/1ps
`default_nettype none
module tb_bit_op_and_call_decoder;
  typedef struct packed {
    logic [23:0]            b;
    logic [1:0]             md;
    logic [31:0]            n;
    bit_call_pkg::op_kind_t k;
    logic [31:0]            t;
  } row_t;
  logic                      clk_sys_in;
  logic                      arst_n_in;
  logic                      insn_valid_in;
  bit_call_pkg::insn_bytes_t insn_in;
  logic                      protected_mode_in;
  logic                      addr_size_32_in;
  logic [31:0]               loop_count_in;
  logic [5:0]                scan_positions_in;
  logic [7:0]                component_clocks_in;
  logic                      insn_ready_out;
  bit_call_pkg::op_kind_t    op_kind_out;
  logic                      imm_index_out;
  logic                      mem_operand_out;
  logic                      wide_operand_out;
  logic [31:0]               total_clocks_out;
  logic                      busy_out;
  logic                      done_out;
  logic                      unknown_out;
  row_t                      u;
  int                        n_errors = 0;
  int                        checks = 0;
  // md is {protected mode, 32-bit count}; n feeds count, scan and component inputs
  row_t rows [21] = '{
    '{24'hF2AA00, 2'h0, 32'h10003, bit_call_pkg::OP_REP_STORE, 32'h14},
    '{24'hF2AB00, 2'h1, 32'h0, bit_call_pkg::OP_REP_STORE, 32'h5},
    '{24'h0FBCC0, 2'h0, 32'h3F, bit_call_pkg::OP_SCAN_FORWARD, 32'hC8},
    '{24'h0FBD00, 2'h0, 32'h0, bit_call_pkg::OP_SCAN_REVERSE, 32'h9},
    '{24'h0FBAE0, 2'h0, 32'h0, bit_call_pkg::OP_TEST_BIT, 32'h3},
    '{24'h0FBA20, 2'h0, 32'h0, bit_call_pkg::OP_TEST_BIT, 32'h6},
    '{24'h0FBAF8, 2'h0, 32'h0, bit_call_pkg::OP_TEST_COMPL, 32'h6},
    '{24'h0FBA38, 2'h0, 32'h0, bit_call_pkg::OP_TEST_COMPL, 32'h8},
    '{24'h0FBA70, 2'h0, 32'h0, bit_call_pkg::OP_TEST_CLEAR, 32'h8},
    '{24'h0FBAE8, 2'h0, 32'h0, bit_call_pkg::OP_TEST_SET, 32'h6},
    '{24'h0FA3C1, 2'h0, 32'h0, bit_call_pkg::OP_TEST_BIT, 32'h3},
    '{24'h0FA306, 2'h0, 32'h0, bit_call_pkg::OP_TEST_BIT, 32'hC},
    '{24'h0FBBC0, 2'h0, 32'h0, bit_call_pkg::OP_TEST_COMPL, 32'h6},
    '{24'h0FBB80, 2'h0, 32'h0, bit_call_pkg::OP_TEST_COMPL, 32'hD},
    '{24'h0FB300, 2'h0, 32'h0, bit_call_pkg::OP_TEST_CLEAR, 32'hD},
    '{24'h0FABC0, 2'h0, 32'h0, bit_call_pkg::OP_TEST_SET, 32'h6},
    '{24'hE80000, 2'h0, 32'h5, bit_call_pkg::OP_NEAR_CALL, 32'hC},
    '{24'h9A0000, 2'h0, 32'h3, bit_call_pkg::OP_FAR_CALL, 32'h14},
    '{24'h9A0000, 2'h2, 32'h0, bit_call_pkg::OP_FAR_CALL, 32'h22},
    '{24'hFFD000, 2'h0, 32'h4, bit_call_pkg::OP_IND_CALL, 32'hB},
    '{24'hFF1000, 2'h0, 32'h4, bit_call_pkg::OP_IND_CALL, 32'hE}};

  bit_op_and_call_decoder DUT (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .insn_valid_in(insn_valid_in),
    .insn_in(insn_in), .protected_mode_in(protected_mode_in), .addr_size_32_in(addr_size_32_in),
    .loop_count_in(loop_count_in), .scan_positions_in(scan_positions_in),
    .component_clocks_in(component_clocks_in), .insn_ready_out(insn_ready_out),
    .op_kind_out(op_kind_out), .imm_index_out(imm_index_out), .mem_operand_out(mem_operand_out),
    .wide_operand_out(wide_operand_out), .total_clocks_out(total_clocks_out),
    .busy_out(busy_out), .done_out(done_out), .unknown_out(unknown_out));

  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic idle_chk();
    chk_num({28'h0, op_kind_out}, {28'h0, bit_call_pkg::OP_NONE});
    chk_num({29'h0, insn_ready_out, busy_out, done_out}, 32'h4);
    $display("test ended at %0t", $time);
  endtask

  // valid stays up after acceptance so every busy cycle also probes refusal
  task automatic go(input row_t r);
    insn_valid_in = 1'b1;
    insn_in = r.b;
    {protected_mode_in, addr_size_32_in} = r.md;
    loop_count_in = r.n;
    scan_positions_in = r.n[5:0];
    component_clocks_in = r.n[7:0];
    @(negedge clk_sys_in);
  endtask

  task automatic fin(input row_t r);
    logic [31:0] c;
    logic [31:0] b;
    logic        mx;
    c = 32'h1;
    b = 32'h0;
    mx = (r.b[23:16] == 8'h0F) ? (r.b[7:6] != 2'h3) :
         (r.b[23:16] == 8'hFF) && (r.b[15:14] != 2'h3);
    chk_num({28'h0, op_kind_out}, {28'h0, r.k});
    chk_num(total_clocks_out, r.t);
    chk_num({31'h0, wide_operand_out}, {31'h0, r.b[23:16] != 8'hF2 || r.b[8]});
    chk_num({31'h0, imm_index_out}, {31'h0, r.b[23:8] == 16'h0FBA});
    chk_num({31'h0, mem_operand_out}, {31'h0, mx});
    while (done_out !== 1'b1 && c < 32'h200)
    begin
      b = b + {31'h0, busy_out};
      @(negedge clk_sys_in);
      c = c + 32'h1;
    end
    chk_num(c, r.t);
    chk_num(b, r.t - 32'h1);
    insn_valid_in = 1'b0;
    @(negedge clk_sys_in);
    $display("test ended at %0t", $time);
  endtask

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // about forty times the expected run length of some 500 cycles
  initial
  begin
    #500000;
    n_errors = n_errors + 1;
    close_out();
  end

  initial
  begin
    arst_n_in = 1'b0;
    insn_valid_in = 1'b0;
    insn_in = 24'h0;
    protected_mode_in = 1'b0;
    addr_size_32_in = 1'b0;
    loop_count_in = 32'h0;
    scan_positions_in = 6'h0;
    component_clocks_in = 8'h0;
    repeat (3) @(negedge clk_sys_in);
    idle_chk();
    arst_n_in = 1'b1;
    @(negedge clk_sys_in);
    foreach (rows[i])
    begin
      go(rows[i]);
      fin(rows[i]);
    end
    // reserved immediate sub-code held valid: one pulse per cycle, never busy
    u = '{24'h0FBA18, 2'h0, 32'h0, bit_call_pkg::OP_NONE, 32'h0};
    go(u);
    chk_num({29'h0, unknown_out, busy_out, insn_ready_out}, 32'h5);
    @(negedge clk_sys_in);
    chk_num({29'h0, unknown_out, busy_out, insn_ready_out}, 32'h5);
    insn_valid_in = 1'b0;
    @(negedge clk_sys_in);
    chk_num({29'h0, unknown_out, busy_out, insn_ready_out}, 32'h1);
    $display("test ended at %0t", $time);
    // a different opcode offered while busy must be ignored
    u = '{24'hE80000, 2'h0, 32'h14, bit_call_pkg::OP_NEAR_CALL, 32'h1B};
    go(u);
    insn_in = 24'h9A0000;
    fin(u);
    chk_num({28'h0, op_kind_out}, {28'h0, bit_call_pkg::OP_NEAR_CALL});
    // full 32-bit count is far too long to run out, so a reset cuts it short
    u = '{24'hF2AB00, 2'h1, 32'h10001, bit_call_pkg::OP_REP_STORE, 32'h5000A};
    go(u);
    chk_num(total_clocks_out, u.t);
    chk_num({29'h0, insn_ready_out, busy_out, done_out}, 32'h2);
    repeat (3) @(negedge clk_sys_in);
    arst_n_in = 1'b0;
    insn_valid_in = 1'b0;
    @(negedge clk_sys_in);
    idle_chk();
    arst_n_in = 1'b1;
    @(negedge clk_sys_in);
    go(rows[0]);
    fin(rows[0]);
    close_out();
  end
endmodule
`default_nettype wire
